// >>> include/wwd_params.svh
// Overview of operation
// - a falling kick edge must land between lower and upper window bounds, else reset
// - at power-up kicks are ignored until the reset delay has expired
// - kicks are ignored while the reset output is held low
// - kicks are ignored while the straps disable the watchdog
// - on timeout the reset output is low for exactly the selected delay
// - when disabled the reset output stays released high once any running reset delay has ended
// - window bits and timeout strap together pick ratio, timeout or disable
// - timeout strap: capacitor, pull-up or open, the last two are presets
// - with capacitor timeout the lower bound comes from the window bits
// - reset delay strap: capacitor, pull-up or open preset delays
// - reset output is active low open drain, only ever pulled low
`ifndef WWD_PARAMS_SVH
`define WWD_PARAMS_SVH

`define WWD_CLK_PERIOD_NS   4
`define WWD_CNT_W           32
// strap codes
`define WWD_STRAP_CAP       2'h0
`define WWD_STRAP_PULLUP    2'h1
`define WWD_STRAP_OPEN      2'h2
// preset times in microseconds
`define WWD_TUP_PULLUP_US   1000
`define WWD_TUP_OPEN_US     200
`define WWD_TUP_CAP_US      400
`define WWD_TRST_PULLUP_US  10
`define WWD_TRST_OPEN_US    200
`define WWD_TRST_CAP_US     50
// window lower bound as upper bound divided by 2**shift
`define WWD_LOW_SHIFT_00    3
`define WWD_LOW_SHIFT_01    1
`define WWD_LOW_SHIFT_10    2

`endif

// >>> include/wwd_pkg.sv
package wwd_pkg;
    typedef enum logic [3:0] {
        WWD_ST_INIT   = 4'h1,
        WWD_ST_WINDOW = 4'h2,
        WWD_ST_RESET  = 4'h4,
        WWD_ST_OFF    = 4'h8
    } wwd_state_t;
endpackage

// >>> rtl/wwd_cfg_decode.sv
`timescale 1ns/1ps
`include "wwd_params.svh"
module wwd_cfg_decode
    import wwd_pkg::*;
(
    // straps
    input  wire logic [1:0]             timeout_strap,
    input  wire logic [1:0]             reset_delay_strap,
    input  wire logic                   window_cfg_bit0,
    input  wire logic                   window_cfg_bit1,
    input  wire logic [`WWD_CNT_W-1:0]  cap_upper_cycles,
    input  wire logic [`WWD_CNT_W-1:0]  cap_delay_cycles,
    // decoded timing
    output logic      [`WWD_CNT_W-1:0]  upper_cycles,
    output logic      [`WWD_CNT_W-1:0]  lower_cycles,
    output logic      [`WWD_CNT_W-1:0]  delay_cycles,
    output logic                        disabled
);
    function automatic logic [`WWD_CNT_W-1:0] us_to_cyc(input int us);
        us_to_cyc = `WWD_CNT_W'((us * 1000) / `WWD_CLK_PERIOD_NS);
    endfunction

    logic [1:0] cfg;
    assign cfg = {window_cfg_bit1, window_cfg_bit0};

    always_comb begin
        // window bits 11 disable the watchdog in every strap setting
        disabled = (cfg == 2'h3);
        case (timeout_strap)
            `WWD_STRAP_CAP:    upper_cycles = cap_upper_cycles;
            `WWD_STRAP_PULLUP: upper_cycles = us_to_cyc(`WWD_TUP_PULLUP_US);
            default:           upper_cycles = us_to_cyc(`WWD_TUP_OPEN_US);
        endcase
        // lower bound always follows the window bits, capacitor case too
        case (cfg)
            2'h0:    lower_cycles = upper_cycles >> `WWD_LOW_SHIFT_00;
            2'h1:    lower_cycles = upper_cycles >> `WWD_LOW_SHIFT_01;
            default: lower_cycles = upper_cycles >> `WWD_LOW_SHIFT_10;
        endcase
        case (reset_delay_strap)
            `WWD_STRAP_CAP:    delay_cycles = cap_delay_cycles;
            `WWD_STRAP_PULLUP: delay_cycles = us_to_cyc(`WWD_TRST_PULLUP_US);
            default:           delay_cycles = us_to_cyc(`WWD_TRST_OPEN_US);
        endcase
    end
endmodule

// >>> rtl/wwd_top.sv
`timescale 1ns/1ps
`include "wwd_params.svh"
module wwd_top
    import wwd_pkg::*;
#(
    parameter logic [`WWD_CNT_W-1:0] CAP_UPPER_CYCLES =
        `WWD_CNT_W'((`WWD_TUP_CAP_US * 1000) / `WWD_CLK_PERIOD_NS),
    parameter logic [`WWD_CNT_W-1:0] CAP_DELAY_CYCLES =
        `WWD_CNT_W'((`WWD_TRST_CAP_US * 1000) / `WWD_CLK_PERIOD_NS)
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // straps
    input  wire logic [1:0]  timeout_strap,
    input  wire logic [1:0]  reset_delay_strap,
    input  wire logic        window_cfg_bit0,
    input  wire logic        window_cfg_bit1,
    // kick
    input  wire logic        kick_input,
    // open-drain reset pin
    output logic             timeout_reset_out_n,
    output logic             timeout_reset_oe
);
    logic [`WWD_CNT_W-1:0] upper_cycles;
    logic [`WWD_CNT_W-1:0] lower_cycles;
    logic [`WWD_CNT_W-1:0] delay_cycles;
    logic                  disabled;
    wwd_state_t            state;
    wwd_state_t            next_state;
    logic [`WWD_CNT_W-1:0] count;
    logic                  kick_prev;
    logic                  kick_fall;
    logic                  early;
    logic                  late;
    logic                  delay_done;
    logic                  kick_edge;
    logic [`WWD_CNT_W-1:0] low_run;

    wwd_cfg_decode u_dec (
        .timeout_strap     (timeout_strap),
        .reset_delay_strap (reset_delay_strap),
        .window_cfg_bit0   (window_cfg_bit0),
        .window_cfg_bit1   (window_cfg_bit1),
        .cap_upper_cycles  (CAP_UPPER_CYCLES),
        .cap_delay_cycles  (CAP_DELAY_CYCLES),
        .upper_cycles      (upper_cycles),
        .lower_cycles      (lower_cycles),
        .delay_cycles      (delay_cycles),
        .disabled          (disabled)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            kick_prev <= 1'b0;
        end else begin
            kick_prev <= kick_input;
        end
    end

    // raw falling edge on the pin, before any state filtering
    assign kick_edge  = kick_prev & ~kick_input;
    // kicks only count while windowing: not during init, reset or disable
    assign kick_fall  = kick_edge & (state == WWD_ST_WINDOW);
    assign early      = kick_fall & (count < lower_cycles);
    assign late       = (count >= upper_cycles - `WWD_CNT_W'(1));
    assign delay_done = (count >= delay_cycles - `WWD_CNT_W'(1));

    always_comb begin
        next_state = state;
        case (state)
            WWD_ST_INIT: begin
                if (delay_done) begin
                    next_state = disabled ? WWD_ST_OFF : WWD_ST_WINDOW;
                end
            end
            WWD_ST_WINDOW: begin
                if (disabled) begin
                    next_state = WWD_ST_OFF;
                end else if (early || (late && !kick_fall)) begin
                    next_state = WWD_ST_RESET;
                end
            end
            WWD_ST_RESET: begin
                if (delay_done) begin
                    next_state = disabled ? WWD_ST_OFF : WWD_ST_WINDOW;
                end
            end
            WWD_ST_OFF: begin
                if (!disabled) begin
                    next_state = WWD_ST_WINDOW;
                end
            end
            default: next_state = WWD_ST_INIT;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= WWD_ST_INIT;
        end else begin
            state <= next_state;
        end
    end

    // counter restarts on each state change and each accepted kick
    always_ff @(posedge clk) begin
        if (rst) begin
            count <= `WWD_CNT_W'(0);
        end else if (next_state != state || kick_fall) begin
            count <= `WWD_CNT_W'(0);
        end else if (state != WWD_ST_OFF) begin
            count <= count + `WWD_CNT_W'(1);
        end
    end

    // pin driven low only while in reset state; high level from external pull-up
    always_ff @(posedge clk) begin
        if (rst) begin
            timeout_reset_out_n <= 1'b1;
            timeout_reset_oe    <= 1'b0;
        end else begin
            timeout_reset_out_n <= (next_state != WWD_ST_RESET);
            timeout_reset_oe    <= (next_state == WWD_ST_RESET);
        end
    end

    // length of the current low pulse on the reset pin
    always_ff @(posedge clk) begin
        if (rst) begin
            low_run <= `WWD_CNT_W'(0);
        end else if (timeout_reset_out_n) begin
            low_run <= `WWD_CNT_W'(0);
        end else begin
            low_run <= low_run + `WWD_CNT_W'(1);
        end
    end

    // pin behaviour and kick filtering
    a_pin_consistent: assert property (@(posedge clk) disable iff (rst)
        timeout_reset_oe == !timeout_reset_out_n)
        else $error("open-drain output drives high");
    a_off_released: assert property (@(posedge clk) disable iff (rst)
        (state == WWD_ST_OFF) |-> timeout_reset_out_n)
        else $error("reset asserted while disabled");
    a_late_resets: assert property (@(posedge clk) disable iff (rst)
        (state == WWD_ST_WINDOW && !disabled && late && !kick_fall) |=> !timeout_reset_out_n)
        else $error("missed kick did not reset");
    a_early_resets: assert property (@(posedge clk) disable iff (rst)
        (state == WWD_ST_WINDOW && !disabled && early) |=> !timeout_reset_out_n)
        else $error("early kick did not reset");
    a_good_kick: assert property (@(posedge clk) disable iff (rst)
        (state == WWD_ST_WINDOW && !disabled && kick_fall && !early) |=> count == 0)
        else $error("window not restarted on kick");
    a_reset_ignores: assert property (@(posedge clk) disable iff (rst)
        (state == WWD_ST_RESET && kick_edge && next_state == WWD_ST_RESET)
        |=> count == $past(count) + `WWD_CNT_W'(1))
        else $error("kick restarted timing during reset");
    a_init_ignores: assert property (@(posedge clk) disable iff (rst)
        (state == WWD_ST_INIT && kick_edge && next_state == WWD_ST_INIT)
        |=> timeout_reset_out_n && count == $past(count) + `WWD_CNT_W'(1))
        else $error("kick accepted during power-up");
    a_off_ignores: assert property (@(posedge clk) disable iff (rst)
        (state == WWD_ST_OFF && kick_edge && disabled)
        |=> state == WWD_ST_OFF && timeout_reset_out_n)
        else $error("kick accepted while disabled");
    a_delay_length: assert property (@(posedge clk) disable iff (rst)
        (state == WWD_ST_RESET && count < delay_cycles - 1) |=> state == WWD_ST_RESET)
        else $error("reset delay ended early");
    a_decode_off: assert property (@(posedge clk) disable iff (rst)
        (window_cfg_bit0 && window_cfg_bit1 && state == WWD_ST_WINDOW) |=> state == WWD_ST_OFF)
        else $error("disable strap not honoured");

    // pin, delay and restart timing
    a_low_in_reset: assert property (@(posedge clk) disable iff (rst)
        (state == WWD_ST_RESET) |-> !timeout_reset_out_n && timeout_reset_oe)
        else $error("reset pin released during reset delay");
    a_high_outside: assert property (@(posedge clk) disable iff (rst)
        (state != WWD_ST_RESET) |-> timeout_reset_out_n && !timeout_reset_oe)
        else $error("reset pin pulled low outside reset delay");
    a_delay_exact: assert property (@(posedge clk) disable iff (rst)
        $rose(timeout_reset_out_n) |-> low_run == delay_cycles)
        else $error("reset pulse length differs from selected delay");
    a_late_bound: assert property (@(posedge clk) disable iff (rst)
        (state == WWD_ST_WINDOW && !disabled && !early
            && count < upper_cycles - `WWD_CNT_W'(1)) |=> state == WWD_ST_WINDOW)
        else $error("reset before upper window bound");
    a_window_counts: assert property (@(posedge clk) disable iff (rst)
        (state == WWD_ST_WINDOW && next_state == WWD_ST_WINDOW && !kick_fall)
        |=> count == $past(count) + `WWD_CNT_W'(1))
        else $error("window timer did not advance");
    a_restart_window: assert property (@(posedge clk) disable iff (rst)
        (state != WWD_ST_WINDOW && next_state == WWD_ST_WINDOW)
        |=> state == WWD_ST_WINDOW && count == `WWD_CNT_W'(0))
        else $error("window not restarted on entry");
    a_init_length: assert property (@(posedge clk) disable iff (rst)
        (state == WWD_ST_INIT && count < delay_cycles - `WWD_CNT_W'(1))
        |=> state == WWD_ST_INIT)
        else $error("power-up delay ended early");
    a_init_to_window: assert property (@(posedge clk) disable iff (rst)
        (state == WWD_ST_INIT && delay_done && !disabled) |=> state == WWD_ST_WINDOW)
        else $error("supervision not started after power-up delay");
    a_reset_to_window: assert property (@(posedge clk) disable iff (rst)
        (state == WWD_ST_RESET && delay_done && !disabled) |=> timeout_reset_out_n)
        else $error("reset pin held past the delay");
    a_off_frozen: assert property (@(posedge clk) disable iff (rst)
        (state == WWD_ST_OFF && disabled) |=> count == $past(count))
        else $error("timer ran while disabled");

    c_timeout: cover property (@(posedge clk) disable iff (rst)
        state == WWD_ST_WINDOW ##1 state == WWD_ST_RESET);
    c_good_kick: cover property (@(posedge clk) disable iff (rst)
        state == WWD_ST_WINDOW && kick_fall && !early);
    c_reset_end: cover property (@(posedge clk) disable iff (rst)
        state == WWD_ST_RESET ##1 state == WWD_ST_WINDOW);
    c_disabled: cover property (@(posedge clk) disable iff (rst)
        state == WWD_ST_OFF);
    c_early_kick: cover property (@(posedge clk) disable iff (rst)
        state == WWD_ST_WINDOW && early);
endmodule

// >>> tb/tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %s exp %0d got %0d", nm, e, g); end end
module tb;
    import wwd_pkg::*;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [1:0] dly_strap = 2'h0;
    logic [1:0] tstrap = 2'h0;
    logic [1:0] cfg = 2'h0;
    logic       kick_req = 1'b0;
    logic       kick_input;
    logic       out_n;
    logic       oe;
    int         n_fail = 0;
    int         n_checks = 0;
    int         cyc = 0;
    int         n;
    int         lo [3] = '{5, 20, 10};
    wwd_kick_model cpu (.clk(clk), .kick_req(kick_req), .kick_input(kick_input));
    wwd_top #(.CAP_UPPER_CYCLES(32'h28), .CAP_DELAY_CYCLES(32'h14)) uut (
        .clk(clk), .rst(rst), .timeout_strap(tstrap), .reset_delay_strap(dly_strap),
        .window_cfg_bit0(cfg[0]), .window_cfg_bit1(cfg[1]), .kick_input(kick_input),
        .timeout_reset_out_n(out_n), .timeout_reset_oe(oe));
    initial forever #2 clk = ~clk;
    task final_report;
        if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // run-time ceiling
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            n_fail++;
            final_report();
        end
    end
    task idle(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    task kick;
        @(posedge clk);
        kick_req <= 1'b1;
        @(posedge clk);
        kick_req <= 1'b0;
        #1;
    endtask
    task wait_low(input int max, output int k);
        k = 0;
        while (out_n !== 1'b0 && k < max) begin
            @(posedge clk);
            #1;
            k++;
        end
    endtask
    // counts low cycles, kicking once while the output is held low
    task low_len(output int k);
        `CHK("oe", 1'b1, oe)
        k = 0;
        do begin
            @(posedge clk);
            kick_req <= (k == 5);
            #1;
            k++;
        end while (out_n === 1'b0);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        idle(3);
        kick();
        wait_low(200, n);
        `CHK("first_timeout", 1'b1, n >= 52 && n <= 60)
        low_len(n);
        `CHK("low_len", 20, n)
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            cfg <= 2'(i);
            idle(lo[i] + 2);
            kick();
            wait_low(100, n);
            `CHK("restart", 1'b1, n >= 36 && n <= 43)
            low_len(n);
            `CHK("low_len", 20, n)
            idle(lo[i] - 4);
            kick();
            wait_low(6, n);
            `CHK("early_kick", 1'b1, n < 6)
            low_len(n);
        end
        @(posedge clk);
        cfg <= 2'h3;
        repeat (3) kick();
        wait_low(100, n);
        `CHK("disabled", 100, n)
        `CHK("disabled_oe", 1'b0, oe)
        @(posedge clk);
        cfg <= 2'h0;
        dly_strap <= 2'h1;
        wait_low(100, n);
        low_len(n);
        `CHK("pullup_delay", 2500, n)
        // preset timeouts: no timeout within 100 cycles, an early kick, then the delay
        for (int j = 1; j < 3; j++) begin
            @(posedge clk);
            tstrap    <= 2'(j);
            dly_strap <= (j == 1) ? 2'h2 : 2'h0;
            wait_low(100, n);
            `CHK("preset_upper", 100, n)
            kick();
            wait_low(6, n);
            `CHK("preset_early", 1'b1, n < 6)
            low_len(n);
            `CHK("preset_delay", (j == 1) ? 50000 : 20, n)
        end
        final_report();
    end
endmodule

// >>> tb/wwd_kick_model.sv
`timescale 1ns/1ps
module wwd_kick_model (
    // clock
    input  wire logic clk,
    // kick request from the bench
    input  wire logic kick_req,
    // kick pin, always at a defined level
    output logic      kick_input
);
    initial kick_input = 1'b1;
    // one falling edge per request, high otherwise
    always @(posedge clk) begin
        kick_input <= ~kick_req;
    end
endmodule
